// File: tfh_pkg.sv
// Purpose: constants and carrier types for the tape frame header encoder
// Assumes: one clock domain, one bit of track stream per accepted symbol
// Notes: field words are held with the first bit on tape in the top bit
package tfh_pkg;
  localparam int DIGIT_W = 4;
  localparam int TC_DIGITS = 12;
  localparam int TC_BITS = TC_DIGITS * DIGIT_W;
  localparam int CRC_W = 16;
  localparam int FIELD_BITS = TC_BITS + CRC_W;
  localparam int AUX_DIGITS = 16;
  localparam int AUX_BITS = AUX_DIGITS * DIGIT_W;
  localparam int REV_FIRST = 8;
  localparam int REV_LAST = 13;
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005;
  localparam logic [CRC_W-1:0] CRC_INIT = 16'h0000;
  localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
  localparam logic [DIGIT_W-1:0] GROUP_MAX = 4'h4;
  localparam logic [DIGIT_W-1:0] SIGN_POS = 4'h0;
  localparam logic [DIGIT_W-1:0] SIGN_NEG = 4'h8;
  localparam logic [DIGIT_W-1:0] HEADSTACK = 4'h0;
  localparam logic [DIGIT_W-1:0] PAD_DIGIT = 4'h0;

  typedef struct packed {
    logic [DIGIT_W-1:0] day_h;
    logic [DIGIT_W-1:0] day_t;
    logic [DIGIT_W-1:0] day_u;
    logic [8:0][DIGIT_W-1:0] sec;
  } tfh_time_t;

  typedef struct packed {
    logic [DIGIT_W-1:0] station_t;
    logic [DIGIT_W-1:0] station_u;
    logic recorder;
    logic pos_neg;
    logic [DIGIT_W-1:0] pos_h;
    logic [DIGIT_W-1:0] pos_t;
    logic [DIGIT_W-1:0] pos_u;
    logic [2:0] track;
    logic [2:0] group;
    logic acquisition_rack_number;
  } tfh_aux_t;

  typedef struct packed {
    logic bit_type;
    logic sideband;
    logic [2:0] baseband_converter;
  } tfh_roll_t;

  typedef enum logic [1:0] {
    FLD_TIME,
    FLD_DATA,
    FLD_AUX,
    FLD_NONE
  } tfh_field_t;

  typedef struct packed {
    logic data;
    tfh_field_t field;
  } tfh_sym_t;
endpackage

// File: tfh_encoder.sv
// Purpose: splices time-code and auxiliary header fields around the data bits
// Assumes: enable_i, header inputs and data are synchronous to clk_i
// Notes: a frame is time code, DATA_BITS data bits, then the auxiliary field
`timescale 1ns/1ps
module tfh_encoder
  import tfh_pkg::*;
#(
  parameter int DATA_BITS = 2480,
  parameter int BUF_W = 1,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire tfh_time_t time_i,
  input wire tfh_aux_t aux_i,
  input wire tfh_roll_t rotates_each_frame_i,
  input wire logic din_valid_i,
  input wire logic [BUF_W-1:0] din_i,
  output logic din_ready_o,
  output logic out_valid_o,
  output tfh_sym_t out_o,
  input wire logic out_ready_i,
  output logic frame_start_o
);

  localparam int CNT_MAX = (DATA_BITS > FIELD_BITS) ? DATA_BITS : FIELD_BITS;
  localparam int CNT_W = $clog2(CNT_MAX + 1);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int BCW = $clog2(BUF_DEPTH + 1);

  generate
    if (DATA_BITS < 1 || BUF_DEPTH < 2 || BUF_W < 1) begin : g_bad
      $error("tfh_encoder: DATA_BITS, BUF_DEPTH or BUF_W out of range");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIME,
    ST_DATA,
    ST_AUX
  } tfh_state_t;

  // saturate a decimal digit into zero..nine
  function automatic logic [DIGIT_W-1:0] bcd_sat(input logic [DIGIT_W-1:0] d);
    return (d > DIGIT_MAX) ? DIGIT_MAX : d;
  endfunction

  function automatic logic [DIGIT_W-1:0] rev_digit(input logic [DIGIT_W-1:0] d);
    logic [DIGIT_W-1:0] r;
    for (int i = 0; i < DIGIT_W; i++) begin
      r[i] = d[DIGIT_W-1-i];
    end
    return r;
  endfunction

  // time-code word, first tape bit in the top position
  function automatic logic [TC_BITS-1:0] tc_word(input tfh_time_t t);
    logic [TC_DIGITS-1:0][DIGIT_W-1:0] w;
    w = t;
    for (int i = 0; i < TC_DIGITS; i++) begin
      w[i] = bcd_sat(w[i]);
    end
    return w;
  endfunction

  // auxiliary word, digit one in the top nibble
  function automatic logic [AUX_BITS-1:0] aux_word(input tfh_aux_t a, input tfh_roll_t r);
    logic [AUX_DIGITS-1:0][DIGIT_W-1:0] dg;
    dg[AUX_DIGITS-1] = bcd_sat(a.station_t);
    dg[AUX_DIGITS-2] = bcd_sat(a.station_u);
    dg[AUX_DIGITS-3] = {3'h0, a.recorder};
    dg[AUX_DIGITS-4] = HEADSTACK;
    dg[AUX_DIGITS-5] = a.pos_neg ? SIGN_NEG : SIGN_POS;
    dg[AUX_DIGITS-6] = bcd_sat(a.pos_h);
    dg[AUX_DIGITS-7] = bcd_sat(a.pos_t);
    dg[AUX_DIGITS-8] = bcd_sat(a.pos_u);
    dg[AUX_DIGITS-9] = {1'h0, a.track};
    dg[AUX_DIGITS-10] = ({1'h0, a.group} > GROUP_MAX) ? GROUP_MAX : {1'h0, a.group};
    dg[AUX_DIGITS-11] = {3'h0, r.bit_type};
    dg[AUX_DIGITS-12] = {3'h0, r.sideband};
    dg[AUX_DIGITS-13] = {1'h0, r.baseband_converter};
    dg[AUX_DIGITS-14] = {3'h0, a.acquisition_rack_number};
    dg[AUX_DIGITS-15] = PAD_DIGIT;
    dg[AUX_DIGITS-16] = PAD_DIGIT;
    for (int i = REV_FIRST; i <= REV_LAST; i++) begin
      dg[AUX_DIGITS-1-i] = rev_digit(dg[AUX_DIGITS-1-i]);
    end
    return dg;
  endfunction

  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
    logic fb;
    fb = b ^ c[CRC_W-1];
    return {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
  endfunction

  // two-entry input buffer so a stall downstream loses no data bit
  logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [BCW-1:0] buf_count;
  logic [BCW-1:0] next_buf_count;
  logic buf_empty;
  logic push;
  logic pop;

  tfh_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [TC_BITS-1:0] tc_sh;
  logic [AUX_BITS-1:0] aux_sh;
  logic [CRC_W-1:0] crc;
  logic ld;
  logic emit;
  logic start;
  logic last;
  logic cur_bit;
  tfh_field_t cur_field;

  assign buf_empty = (buf_count == '0);
  assign push = din_valid_i && din_ready_o;
  assign pop = emit && (state == ST_DATA);
  assign ld = !out_valid_o || out_ready_i;
  assign start = ld && enable_i && ((state == ST_IDLE) || ((state == ST_AUX) && last));

  always_comb begin
    next_buf_count = buf_count;
    if (push && !pop) begin
      next_buf_count = buf_count + BCW'(1);
    end else if (pop && !push) begin
      next_buf_count = buf_count - BCW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_count <= '0;
      din_ready_o <= 1'b0;
    end else begin
      buf_count <= next_buf_count;
      din_ready_o <= (next_buf_count < BCW'(BUF_DEPTH));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_mem[wr_ptr] <= din_i;
    end
  end

  // symbol selection for the current state
  always_comb begin
    cur_bit = 1'b0;
    cur_field = FLD_NONE;
    last = 1'b0;
    emit = 1'b0;
    unique case (state)
      ST_IDLE: begin
        emit = 1'b0;
      end
      ST_TIME: begin
        emit = ld;
        cur_field = FLD_TIME;
        cur_bit = (cnt < CNT_W'(TC_BITS)) ? tc_sh[TC_BITS-1] : crc[CRC_W-1];
        last = (cnt == CNT_W'(FIELD_BITS - 1));
      end
      ST_DATA: begin
        emit = ld && !buf_empty;
        cur_field = FLD_DATA;
        cur_bit = buf_mem[rd_ptr][0];
        last = (cnt == CNT_W'(DATA_BITS - 1));
      end
      ST_AUX: begin
        emit = ld;
        cur_field = FLD_AUX;
        cur_bit = aux_sh[AUX_BITS-1];
        last = (cnt == CNT_W'(AUX_BITS - 1));
      end
    endcase
  end

  // frame sequencing: time code, data, then the closing auxiliary field
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else if (start) begin
      state <= ST_TIME;
      cnt <= '0;
    end else if (emit) begin
      if (last) begin
        cnt <= '0;
        unique case (state)
          ST_TIME: state <= ST_DATA;
          ST_DATA: state <= ST_AUX;
          ST_AUX: state <= ST_IDLE;
          ST_IDLE: state <= ST_IDLE;
        endcase
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // header words are captured once per frame, before its data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_sh <= '0;
      aux_sh <= '0;
    end else if (start) begin
      tc_sh <= tc_word(time_i);
      aux_sh <= aux_word(aux_i, rotates_each_frame_i);
    end else if (emit && (state == ST_TIME)) begin
      tc_sh <= {tc_sh[TC_BITS-2:0], 1'b0};
    end else if (emit && (state == ST_AUX)) begin
      aux_sh <= {aux_sh[AUX_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc <= CRC_INIT;
    end else if (start) begin
      crc <= CRC_INIT;
    end else if (emit && (state == ST_TIME)) begin
      if (cnt < CNT_W'(TC_BITS)) begin
        crc <= crc_step(crc, tc_sh[TC_BITS-1]);
      end else begin
        crc <= {crc[CRC_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_o <= '{data: 1'b0, field: FLD_NONE};
    end else if (ld) begin
      out_valid_o <= emit;
      if (emit) begin
        out_o <= '{data: cur_bit, field: cur_field};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_start_o <= 1'b0;
    end else begin
      frame_start_o <= start;
    end
  end

endmodule

// File: tfh_sink_model.sv
// Purpose: model of the tape write channel taking header and data symbols
// Assumes: one clock, ready driven at the falling edge
// Notes: slow_i makes it stall at random symbols
`timescale 1ns/1ps
module tfh_sink_model (
  input wire logic clk_i,
  input wire logic slow_i,
  output logic ready_o
);
  initial ready_o = 1'h0;
  // a refused symbol must be offered again unchanged
  always @(negedge clk_i) begin
    ready_o <= slow_i ? ($urandom % 3 == 0) : 1'h1;
  end
endmodule

// File: tfh_encoder_assertions.sv
// Purpose: port checks of frame layout and stall behaviour
// Assumes: frames start at symbol index zero after reset
// Notes: ix counts symbols handed over within the frame
`timescale 1ns/1ps
module tfh_encoder_checker
  import tfh_pkg::*;
#(
  parameter int DATA_BITS = 2480
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic out_valid_o,
  input wire tfh_sym_t out_o,
  input wire logic out_ready_i,
  input wire logic frame_start_o
);
  localparam int AUX0 = FIELD_BITS + DATA_BITS;
  int ix;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ix <= 0;
    end else if (out_valid_o && out_ready_i) begin
      ix <= (ix == AUX0 + AUX_BITS - 1) ? 0 : ix + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sym_hold_a:
    assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o))
    else $error("symbol changed under stall");
  start_first_a:
    assert property (frame_start_o |-> (!out_valid_o && ix == 0) ||
      (out_valid_o && out_o.field == FLD_AUX && ix == AUX0 + AUX_BITS - 1))
    else $error("frame start not at first time bit");
  time_field_a:
    assert property (out_valid_o && ix < FIELD_BITS |-> out_o.field == FLD_TIME)
    else $error("time field wrong length");
  data_field_a:
    assert property (out_valid_o && ix >= FIELD_BITS && ix < AUX0 |-> out_o.field == FLD_DATA)
    else $error("data field wrong place");
  aux_field_a:
    assert property (out_valid_o && ix >= AUX0 |-> out_o.field == FLD_AUX)
    else $error("aux field not at frame end");
  pad_zero_a:
    assert property (out_valid_o && ix >= AUX0 + 56 |-> !out_o.data)
    else $error("pad digit not zero");
  headstack_zero_a:
    assert property (out_valid_o && ix >= AUX0 + 12 && ix < AUX0 + 16 |-> !out_o.data)
    else $error("headstack digit not zero");
  sign_low_a:
    assert property (out_valid_o && ix >= AUX0 + 17 && ix < AUX0 + 20 |-> !out_o.data)
    else $error("sign digit not 0 or 8");
  cover property (frame_start_o);
  cover property (out_valid_o && !out_ready_i && out_o.field == FLD_DATA);
  cover property (!out_valid_o && ix >= FIELD_BITS && ix < AUX0);
endmodule
bind tfh_encoder tfh_encoder_checker #(.DATA_BITS(DATA_BITS)) u_tfh_encoder_checker (
  .clk_i(clk_i), .rst_i(rst_i), .out_valid_o(out_valid_o), .out_o(out_o),
  .out_ready_i(out_ready_i), .frame_start_o(frame_start_o));

// File: tfh_encoder_tb.sv
// Purpose: random frames with stalls, compared bit by bit
// Assumes: eight data bits per frame
// Notes: one corner frame carries digits above nine
`timescale 1ns/1ps
module tfh_encoder_tb;
  import tfh_pkg::*;
  localparam int DB = 8;
  logic clk_i = 0, rst_i = 1, enable_i = 0, din_valid_i = 0, slow = 0, took = 0, src = 0;
  logic seen = 0;
  logic [0:0] din_i = 1'h0;
  tfh_time_t time_i = '0;
  tfh_aux_t aux_i = '0;
  tfh_roll_t roll = '0;
  logic din_ready_o, out_valid_o, out_ready_i, frame_start_o;
  tfh_sym_t out_o;
  int failures = 0, n_tests = 0;
  bit sent[$];
  tfh_sym_t rx[$];
  logic [63:0] et[$], ea[$];
  tfh_encoder #(.DATA_BITS(DB)) u_tfh_encoder (.clk_i(clk_i), .rst_i(rst_i),
    .enable_i(enable_i), .time_i(time_i), .aux_i(aux_i), .rotates_each_frame_i(roll),
    .din_valid_i(din_valid_i), .din_i(din_i), .din_ready_o(din_ready_o),
    .out_valid_o(out_valid_o), .out_o(out_o), .out_ready_i(out_ready_i),
    .frame_start_o(frame_start_o));
  tfh_sink_model u_tfh_sink_model (.clk_i(clk_i), .slow_i(slow), .ready_o(out_ready_i));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    took <= din_valid_i && din_ready_o;
    if (din_valid_i && din_ready_o) sent.push_back(din_i[0]);
    if (out_valid_o && out_ready_i) rx.push_back(out_o);
  end
  // a bit is held until taken, with random gaps between bits
  always @(negedge clk_i) begin
    if (src && (!din_valid_i || took)) begin
      din_valid_i <= $urandom % 4 != 0;
      din_i <= 1'($urandom);
    end
  end
  function automatic logic [3:0] sat(logic [3:0] d, logic [3:0] m);
    return d > m ? m : d;
  endfunction
  function automatic logic [3:0] rev(logic [3:0] d);
    return {d[0], d[1], d[2], d[3]};
  endfunction
  function automatic logic [63:0] exp_time(tfh_time_t t);
    logic [63:0] v;
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 12; i++) v[63-4*i -: 4] = sat(t[47-4*i -: 4], 4'h9);
    for (int i = 63; i > 15; i--) c = {c[14:0], 1'h0} ^ ((v[i] ^ c[15]) ? 16'h8005 : 16'h0);
    v[15:0] = c;
    return v;
  endfunction
  function automatic logic [63:0] exp_aux(tfh_aux_t a, tfh_roll_t r);
    return {sat(a.station_t, 4'h9), sat(a.station_u, 4'h9), 3'h0, a.recorder, 4'h0,
      a.pos_neg ? 4'h8 : 4'h0, sat(a.pos_h, 4'h9), sat(a.pos_t, 4'h9), sat(a.pos_u, 4'h9),
      rev({1'h0, a.track}), rev(sat({1'h0, a.group}, 4'h4)), rev({3'h0, r.bit_type}),
      rev({3'h0, r.sideband}), rev({1'h0, r.baseband_converter}),
      rev({3'h0, a.acquisition_rack_number}), 8'h00};
  endfunction
  task automatic fail(string m);
    failures++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic new_inputs(bit corner);
    logic [47:0] tv;
    for (int i = 0; i < 12; i++) tv[4*i +: 4] = corner ? 4'hF : 4'($urandom % 10);
    time_i <= tv;
    aux_i <= corner ? '1 : {4'($urandom % 10), 4'($urandom % 10), 2'($urandom),
      4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 3'($urandom),
      3'($urandom % 5), 1'($urandom)};
    roll <= 5'($urandom);
  endtask
  task automatic check_frame();
    tfh_sym_t s;
    tfh_field_t ef;
    logic e;
    logic [63:0] t, a;
    for (int i = 0; i < 128 + DB; i++) begin
      for (int w = 0; w < 3000 && rx.size() == 0; w++) @(posedge clk_i);
      if (rx.size() == 0 || (i == 0 && et.size() == 0)) begin
        fail("no symbol");
        final_report();
      end
      if (i == 0) t = et.pop_front();
      if (i == 0) a = ea.pop_front();
      s = rx.pop_front();
      ef = i < 64 ? FLD_TIME : i < 64 + DB ? FLD_DATA : FLD_AUX;
      e = i < 64 ? t[63-i] : i < 64 + DB ? sent.pop_front() : a[127+DB-i];
      n_tests++;
      if (s.data !== e || s.field !== ef) fail("symbol mismatch");
    end
  endtask
  initial begin
    void'($urandom(15));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) rst_i = 0;
    repeat (2) @(negedge clk_i);
    src = 1;
    new_inputs(0);
    enable_i <= 1;
    fork
      for (int f = 0; f < 6; f++) begin
        seen = 0;
        for (int w = 0; w < 3000 && !seen; w++) begin
          @(negedge clk_i);
          seen = (frame_start_o === 1'h1);
        end
        if (!seen) begin
          fail("no frame start");
          final_report();
        end
        et.push_back(exp_time(time_i));
        ea.push_back(exp_aux(aux_i, roll));
        slow <= f[0];
        new_inputs(f == 1);
        if (f == 5) enable_i <= 0;
      end
      for (int f = 0; f < 6; f++) check_frame();
    join
    final_report();
  end
endmodule
